/* File: common/fault_log_pkg.sv */
// Package for the fault log image formatter: layout offsets, cause codes,
// timing constants and the telemetry carrier types.
// Assumes a single 40 MHz core clock shared by every user of the package.
package fault_log_pkg;

    // Image geometry
    localparam int LOG_BYTES = 147;
    localparam int HDR_BYTES = 27;
    localparam int REC_BYTES = 20;
    localparam int NUM_RECS = 6;
    localparam int NUM_PEAKS = 5;

    // Header byte offsets
    localparam int PREFACE_OFS = 0;
    localparam int CAUSE_OFS = 4;
    localparam int STAMP_OFS = 5;
    localparam int PEAK_OFS = 11;
    localparam int TEMP_OFS = 21;
    localparam int REC0_OFS = 27;

    // Offsets inside one event record
    localparam int REC_UNUSED_OFS = 10;
    localparam int REC_STATUS_OFS = 12;

    // Preface contents; arbitrary neutral values, not a real part code
    localparam logic [7:0] PREFACE_CHAR0 = 8'h41;
    localparam logic [7:0] PREFACE_CHAR1 = 8'h42;
    localparam logic [15:0] PREFACE_WORD = 16'h0000;

    // Cause codes, channel 0; channel 1 adds CAUSE_CH1_OFS
    localparam logic [3:0] CAUSE_START_TIMEOUT = 4'h0;
    localparam logic [3:0] CAUSE_OVERVOLT = 4'h1;
    localparam logic [3:0] CAUSE_UNDERVOLT = 4'h2;
    localparam logic [3:0] CAUSE_OVERCURR = 4'h3;
    localparam logic [3:0] CAUSE_OVERTEMP = 4'h5;
    localparam logic [3:0] CAUSE_UNDERTEMP = 4'h6;
    localparam logic [3:0] CAUSE_INPUT_OV = 4'h7;
    localparam logic [3:0] CAUSE_INT_TEMP = 4'hA;
    localparam logic [7:0] CAUSE_CH1_OFS = 8'h10;
    localparam logic [7:0] CAUSE_MANUAL = 8'hFF;

    // Timestamp tick: 200 us at a 25 ns clock
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS = 200000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int STAMP_WIDTH = 48;

    // One event record, packed in transmit order (byte 0 in the top bits)
    typedef struct packed {
        logic [15:0] vout0;
        logic [15:0] vout1;
        logic [15:0] iout0;
        logic [15:0] iout1;
        logic [15:0] vin;
        logic [15:0] unused;
        logic [7:0] statusVout0;
        logic [7:0] statusVout1;
        logic [15:0] statusWord0;
        logic [15:0] statusWord1;
        logic [7:0] statusMfr0;
        logic [7:0] statusMfr1;
    } event_rec_t;

    // One completed telemetry cycle as delivered by the monitor
    typedef struct packed {
        event_rec_t rec;
        logic [15:0] tempExt0;
        logic [15:0] tempExt1;
        logic [15:0] tempInt;
    } telem_t;

    // Fault report: manual store overrides channel and kind
    typedef struct packed {
        logic manual;
        logic channel;
        logic [3:0] kind;
    } fault_src_t;

endpackage

/* File: rtl/peak_hold.sv */
// Running maximum of one telemetry quantity.
// Assumes samples are unsigned-comparable raw codes from the monitor.
`timescale 1ns/100ps
module peak_hold #(
    parameter int WIDTH = 16
) (
    // Clock and control
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic clear,
    // Sample stream
    input wire logic sampleValid,
    input wire logic [WIDTH-1:0] sample,
    // Held maximum
    output logic [WIDTH-1:0] peak
);
    logic [WIDTH-1:0] next_peak; // Next maximum

    // Refuse an empty sample width at elaboration
    if (WIDTH < 1)
    begin : g_bad_width
        $error("peak_hold needs WIDTH of at least one");
    end

    // Clear wins over a sample; otherwise keep the larger value
    always_comb
    begin
        next_peak = peak;
        if (clear)
        begin
            next_peak = '0;
        end
        else if (sampleValid && sample > peak)
        begin
            next_peak = sample;
        end
    end

    // Register only
    always_ff @(posedge core_clk)
    begin
        if (rst)
            peak <= '0;
        else if (clkEn)
            peak <= next_peak;
    end

    // Only a clear may lower the maximum
    a_peak_monotone: assert property (@(posedge core_clk)
        disable iff (rst)
        clkEn && !clear |=> peak >= $past(peak))
        else $error("peak dropped without clear");

endmodule // peak_hold

/* File: rtl/fault_log_formatter.sv */
// Fault log formatter: keeps telemetry history and peaks, freezes them
// into one log image on a fault, and serves that image byte by byte.
// Assumes all inputs are synchronous to core_clk and single-cycle pulses.
`timescale 1ns/100ps
module fault_log_formatter #(
    parameter int TICK_LEN = fault_log_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Telemetry from the monitor
    input wire logic eventValid,
    input wire fault_log_pkg::telem_t eventData,
    // Fault trigger and commands
    input wire logic faultValid,
    input wire fault_log_pkg::fault_src_t faultSrc,
    input wire logic peakResetCmd,
    input wire logic logClearCmd,
    // Host readout
    input wire logic readStart,
    input wire logic byteReq,
    output logic countValid,
    output logic [7:0] byteCount,
    output logic byteValid,
    output logic [7:0] readByte,
    output logic logPresent
);
    import fault_log_pkg::*;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_SERVE = 2'b10
    } rd_state_t;

    // Pick byte k of a record, byte 0 being the top of the packed struct
    function automatic logic [7:0] recByte(event_rec_t r, int k);
        recByte = r[(REC_BYTES-1-k)*8 +: 8];
    endfunction

    // Larger of two raw codes, compared as the trackers do
    function automatic logic [15:0] wordMax(logic [15:0] a,
        logic [15:0] b);
        wordMax = (b > a) ? b : a;
    endfunction

    // Refuse a zero-length tick at elaboration
    if (TICK_LEN < 1)
    begin : g_bad_tick
        $error("TICK_LEN must be at least one cycle");
    end

    // Timestamp state
    logic [31:0] tickCnt, next_tickCnt; // Prescaler to 200 us
    logic [STAMP_WIDTH-1:0] stamp, next_stamp; // Free-running stamp
    // Capture state
    event_rec_t history [NUM_RECS]; // Newest first
    event_rec_t next_history [NUM_RECS];
    logic [15:0] lastTemps [3], next_lastTemps [3]; // Temps of last event
    logic pendingFault, next_pendingFault; // Fault seen, record open
    logic next_logPresent;
    logic [7:0] causeCode, next_causeCode;
    logic [STAMP_WIDTH-1:0] stampSnap, next_stampSnap;
    logic [15:0] peakSnap [NUM_PEAKS], next_peakSnap [NUM_PEAKS];
    // Peak trackers
    logic [15:0] peakSample [NUM_PEAKS];
    logic [15:0] peakNow [NUM_PEAKS];
    // Readout state
    rd_state_t rdState, next_rdState;
    logic [7:0] byteIdx, next_byteIdx; // Next byte to send
    logic [7:0] servedIdx, next_servedIdx; // Index of byte on readByte
    logic next_countValid, next_byteValid;
    logic [7:0] next_byteCount, next_readByte;
    logic [7:0] image [LOG_BYTES]; // Assembled log image
    logic captureOk; // History still recording

    // Peak quantities in header order
    assign peakSample[0] = eventData.rec.vout0;
    assign peakSample[1] = eventData.rec.vout1;
    assign peakSample[2] = eventData.rec.iout0;
    assign peakSample[3] = eventData.rec.iout1;
    assign peakSample[4] = eventData.rec.vin;

    // One tracker per peak; they keep running after the log freezes
    for (genvar p = 0; p < NUM_PEAKS; p++)
    begin : g_peak
        peak_hold #(.WIDTH(16)) u_peak (
            .core_clk(core_clk),
            .rst(rst),
            .clkEn(clkEn),
            .clear(peakResetCmd),
            .sampleValid(eventValid),
            .sample(peakSample[p]),
            .peak(peakNow[p])
        );
    end

    // Timestamp: one step every TICK_LEN cycles
    always_comb
    begin
        next_tickCnt = tickCnt + 32'h1;
        next_stamp = stamp;
        if (tickCnt == 32'(TICK_LEN - 1))
        begin
            next_tickCnt = 32'h0;
            next_stamp = stamp + 48'h1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            tickCnt <= 32'h0;
            stamp <= 48'h0;
        end
        else if (clkEn)
        begin
            tickCnt <= next_tickCnt;
            stamp <= next_stamp;
        end
    end

    // History and fault capture; a log, once complete, stays frozen
    // until cleared, so a read never sees a half-updated image
    assign captureOk = !logPresent;
    always_comb
    begin
        next_history = history;
        next_lastTemps = lastTemps;
        next_pendingFault = pendingFault;
        next_logPresent = logPresent;
        next_causeCode = causeCode;
        next_stampSnap = stampSnap;
        next_peakSnap = peakSnap;
        // Clear first, so a completion in the same cycle still wins;
        // it is ignored mid-read to keep the image whole
        if (logClearCmd && rdState == RD_IDLE && !readStart)
        begin
            next_logPresent = 1'b0;
            next_pendingFault = 1'b0;
        end
        if (faultValid && captureOk && !pendingFault)
        begin
            // Cause and stamp taken at the fault itself
            next_pendingFault = 1'b1;
            next_causeCode = faultSrc.manual ? CAUSE_MANUAL :
                {3'h0, faultSrc.channel, faultSrc.kind};
            next_stampSnap = stamp;
        end
        if (eventValid && captureOk)
        begin
            // Shift in newest, oldest falls off
            for (int r = NUM_RECS - 1; r > 0; r--)
            begin
                next_history[r] = history[r-1];
            end
            next_history[0] = eventData.rec;
            next_history[0].unused = 16'h0000;
            next_lastTemps[0] = eventData.tempExt0;
            next_lastTemps[1] = eventData.tempExt1;
            next_lastTemps[2] = eventData.tempInt;
            if (pendingFault)
            begin
                // The cycle running at the fault completes the log
                next_pendingFault = 1'b0;
                next_logPresent = 1'b1;
                // The record's own readings belong in its peaks
                for (int p = 0; p < NUM_PEAKS; p++)
                begin
                    next_peakSnap[p] = peakResetCmd ? 16'h0000 :
                        wordMax(peakNow[p], peakSample[p]);
                end
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            history <= '{default: '0};
            lastTemps <= '{default: '0};
            pendingFault <= 1'b0;
            logPresent <= 1'b0;
            causeCode <= 8'h00;
            stampSnap <= 48'h0;
            peakSnap <= '{default: '0};
        end
        else if (clkEn)
        begin
            history <= next_history;
            lastTemps <= next_lastTemps;
            pendingFault <= next_pendingFault;
            logPresent <= next_logPresent;
            causeCode <= next_causeCode;
            stampSnap <= next_stampSnap;
            peakSnap <= next_peakSnap;
        end
    end

    // Image assembly from the frozen snapshot
    always_comb
    begin
        image[PREFACE_OFS] = PREFACE_CHAR0;
        image[PREFACE_OFS+1] = PREFACE_CHAR1;
        image[PREFACE_OFS+2] = PREFACE_WORD[15:8];
        image[PREFACE_OFS+3] = PREFACE_WORD[7:0];
        image[CAUSE_OFS] = causeCode;
        for (int b = 0; b < 6; b++)
        begin
            image[STAMP_OFS+b] = stampSnap[b*8 +: 8];
        end
        for (int p = 0; p < NUM_PEAKS; p++)
        begin
            image[PEAK_OFS+2*p] = peakSnap[p][15:8];
            image[PEAK_OFS+2*p+1] = peakSnap[p][7:0];
        end
        for (int t = 0; t < 3; t++)
        begin
            image[TEMP_OFS+2*t] = lastTemps[t][15:8];
            image[TEMP_OFS+2*t+1] = lastTemps[t][7:0];
        end
        for (int r = 0; r < NUM_RECS; r++)
        begin
            for (int k = 0; k < REC_BYTES; k++)
            begin
                image[REC0_OFS+REC_BYTES*r+k] =
                    recByte(history[r], k);
            end
        end
    end

    // Readout: count first, then one byte per request, ascending
    always_comb
    begin
        next_rdState = rdState;
        next_byteIdx = byteIdx;
        next_servedIdx = servedIdx;
        next_countValid = 1'b0;
        next_byteCount = byteCount;
        next_byteValid = 1'b0;
        next_readByte = readByte;
        case (rdState)
            RD_IDLE:
            begin
                if (readStart)
                begin
                    next_countValid = 1'b1;
                    next_byteCount = logPresent ? 8'(LOG_BYTES) :
                        8'h00;
                    next_byteIdx = 8'h00;
                    if (logPresent)
                        next_rdState = RD_SERVE;
                end
            end
            RD_SERVE:
            begin
                if (byteReq)
                begin
                    next_byteValid = 1'b1;
                    next_readByte = image[byteIdx];
                    next_servedIdx = byteIdx;
                    next_byteIdx = byteIdx + 8'h01;
                    if (byteIdx == 8'(LOG_BYTES - 1))
                        next_rdState = RD_IDLE;
                end
            end
            default:
                next_rdState = RD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rdState <= RD_IDLE;
            byteIdx <= 8'h00;
            servedIdx <= 8'h00;
            countValid <= 1'b0;
            byteCount <= 8'h00;
            byteValid <= 1'b0;
            readByte <= 8'h00;
        end
        else if (clkEn)
        begin
            rdState <= next_rdState;
            byteIdx <= next_byteIdx;
            servedIdx <= next_servedIdx;
            countValid <= next_countValid;
            byteCount <= next_byteCount;
            byteValid <= next_byteValid;
            readByte <= next_readByte;
        end
    end

    // Checks on what the block drives
    a_block_count: assert property (@(posedge core_clk)
        disable iff (rst)
        clkEn && readStart && rdState == RD_IDLE |=> countValid &&
            byteCount == ($past(logPresent) ? 8'(LOG_BYTES) : 8'h00))
        else $error("wrong block count");
    a_preface_char: assert property (@(posedge core_clk)
        disable iff (rst)
        byteValid && servedIdx == 8'h00 |-> readByte == PREFACE_CHAR0)
        else $error("preface byte wrong");
    a_cause_byte: assert property (@(posedge core_clk)
        disable iff (rst)
        byteValid && servedIdx == 8'h04 |-> readByte == causeCode)
        else $error("cause byte wrong");
    a_stamp_order: assert property (@(posedge core_clk)
        disable iff (rst)
        byteValid && servedIdx == 8'h0A |-> readByte == stampSnap[47:40])
        else $error("stamp not LSB first");
    a_peak_high: assert property (@(posedge core_clk)
        disable iff (rst)
        byteValid && servedIdx == 8'h13 |-> readByte == peakSnap[4][15:8])
        else $error("input peak byte wrong");
    a_temp_last: assert property (@(posedge core_clk)
        disable iff (rst)
        byteValid && servedIdx == 8'h19 |-> readByte == lastTemps[2][15:8])
        else $error("internal temp byte wrong");
    a_record_status: assert property (@(posedge core_clk)
        disable iff (rst)
        byteValid && servedIdx == 8'h27 |-> readByte == history[0].statusVout0)
        else $error("record status byte wrong");
    a_older_slot: assert property (@(posedge core_clk)
        disable iff (rst)
        byteValid && servedIdx == 8'h92 |-> readByte == history[5].statusMfr1)
        else $error("oldest record misplaced");
    a_ascending: assert property (@(posedge core_clk)
        disable iff (rst || !clkEn)
        clkEn && byteReq && rdState == RD_SERVE && byteIdx != 8'h00 |=>
            byteValid && servedIdx == $past(servedIdx) + 8'h01)
        else $error("bytes not ascending");
    a_frozen_log: assert property (@(posedge core_clk)
        disable iff (rst)
        rdState == RD_SERVE |=> $stable(causeCode) && $stable(stampSnap))
        else $error("image changed during read");

    c_empty_read: cover property (@(posedge core_clk)
        countValid && byteCount == 8'h00);
    c_full_read: cover property (@(posedge core_clk)
        byteValid && servedIdx == 8'h92);
    c_manual_store: cover property (@(posedge core_clk)
        logPresent && causeCode == CAUSE_MANUAL);

endmodule // fault_log_formatter

/* File: tb/log_host_model.sv */
// Host side model: runs one block read of the fault log image.
// Assumes one-cycle answers and requests sampled on core_clk rising edges.
`timescale 1ns/100ps
module log_host_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Requests to the formatter
    output logic readStart,
    output logic byteReq,
    // Answers from the formatter
    input wire logic countValid,
    input wire logic [7:0] byteCount,
    input wire logic byteValid,
    input wire logic [7:0] readByte
);
    logic [7:0] img [0:146]; // Bytes in arrival order
    logic [7:0] gotCount; // Byte count of the last read
    int nGot; // Bytes received in the last read

    // Idle until a read is asked for
    initial
    begin
        readStart = 1'b0;
        byteReq = 1'b0;
    end

    // One block read; extra asks one byte past the end on purpose
    task automatic readLog(input bit extra, output bit ok);
        int nReq;
        nGot = 0;
        nReq = 0;
        gotCount = 8'h00;
        ok = 1'b0;
        @(posedge core_clk);
        readStart <= 1'b1;
        @(posedge core_clk);
        readStart <= 1'b0;
        // Count answer must come within a few edges
        for (int w = 0; w < 4 && !ok; w++)
        begin
            @(posedge core_clk);
            if (countValid === 1'b1)
                ok = 1'b1;
        end
        gotCount = byteCount;
        // Empty log: nothing to fetch
        if (!ok || gotCount === 8'h00)
            return;
        // Back to back requests; a stray one past the end is ignored
        for (int w = 0; w < 160; w++)
        begin
            if (byteValid === 1'b1 && nGot < 147)
                img[nGot] = readByte;
            if (byteValid === 1'b1)
                nGot++;
            byteReq <= (nReq < 147 + extra);
            if (nReq < 147 + extra)
                nReq++;
            @(posedge core_clk);
        end
        byteReq <= 1'b0;
    endtask
endmodule // log_host_model

/* File: tb/tb_top.sv */
// Testbench for the fault log formatter: feeds telemetry and faults,
// reads the image through the host model and checks every byte.
// Assumes one-cycle read answers and a shortened 4-cycle stamp tick.
`timescale 1ns/100ps
module tb_top;
    import fault_log_pkg::*;
    localparam int TICK = 4; // Short stamp tick keeps the run brief
    logic core_clk, rst, clkEn, eventValid, faultValid;
    logic peakResetCmd, logClearCmd, readStart, byteReq;
    logic countValid, byteValid, logPresent;
    logic [7:0] byteCount, readByte;
    telem_t eventData;
    fault_src_t faultSrc;
    // Bench copy of what the image should hold
    telem_t hist [0:5];
    logic [15:0] peaks [0:4];
    logic [15:0] snap [0:4];
    logic [7:0] expImg [0:146];
    logic [7:0] got [0:146];
    logic [7:0] expCause, k;
    logic present, pend;
    int n_errors, check_count, cyc, fcyc;
    bit ok;
    // Table rows: fault report beside the cause byte it should give
    typedef struct packed {fault_src_t src; logic [7:0] cause;} row_t;
    row_t rows [0:16];
    logic [3:0] kinds [0:7];

    fault_log_formatter #(.TICK_LEN(TICK)) fault_log_formatter_inst (
        .core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .eventValid(eventValid), .eventData(eventData),
        .faultValid(faultValid), .faultSrc(faultSrc),
        .peakResetCmd(peakResetCmd), .logClearCmd(logClearCmd),
        .readStart(readStart), .byteReq(byteReq),
        .countValid(countValid), .byteCount(byteCount),
        .byteValid(byteValid), .readByte(readByte),
        .logPresent(logPresent));

    log_host_model log_host_model_inst (
        .core_clk(core_clk), .rst(rst), .readStart(readStart),
        .byteReq(byteReq), .countValid(countValid), .byteCount(byteCount),
        .byteValid(byteValid), .readByte(readByte));

    // 40 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Cycles since reset, to predict the captured stamp
    always @(posedge core_clk)
        cyc <= rst ? 0 : cyc + 1;

    // Compare and count
    task automatic check(input string name, input logic [47:0] seen,
        input logic [47:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One telemetry cycle; hi readings beat every low one
    task automatic sendEvent(input bit hi);
        telem_t e;
        logic [7:0] h;
        logic [79:0] pv;
        k = k + 8'h01;
        h = hi ? 8'hC0 : 8'h00;
        e.rec = '{{h + 8'h21, k}, {h + 8'h22, ~k}, {h + 8'h23, k ^ 8'h3C},
            {h + 8'h24, k}, {h + 8'h25, ~k}, 16'hBEEF, k, ~k, {k, 8'hA5},
            {8'h5A, k}, ~k, k + 8'h01};
        e.tempExt0 = {8'h01, k};
        e.tempExt1 = {8'h02, k};
        e.tempInt = {8'h03, k};
        @(posedge core_clk);
        eventValid <= 1'b1;
        eventData <= e;
        @(posedge core_clk);
        eventValid <= 1'b0;
        // Peaks always track; history freezes once a log exists
        pv = {e.rec.vout0, e.rec.vout1, e.rec.iout0, e.rec.iout1, e.rec.vin};
        for (int i = 0; i < 5; i++)
            if (pv[79-16*i -: 16] > peaks[i])
                peaks[i] = pv[79-16*i -: 16];
        if (!present)
        begin
            for (int i = 5; i > 0; i--)
                hist[i] = hist[i-1];
            hist[0] = e;
            if (pend)
            begin
                present = 1'b1;
                pend = 1'b0;
                snap = peaks;
            end
        end
    endtask

    // Fault report; only taken when no log and none pending
    task automatic fault(input fault_src_t s, input logic [7:0] c);
        @(posedge core_clk);
        faultValid <= 1'b1;
        faultSrc <= s;
        @(posedge core_clk);
        faultValid <= 1'b0;
        if (!present && !pend)
        begin
            pend = 1'b1;
            expCause = c;
            fcyc = cyc;
        end
    endtask

    // Log erase or peak clear pulse
    task automatic pulseCmd(input bit clr);
        @(posedge core_clk);
        logClearCmd <= clr;
        peakResetCmd <= !clr;
        @(posedge core_clk);
        logClearCmd <= 1'b0;
        peakResetCmd <= 1'b0;
        if (clr)
        begin
            present = 1'b0;
            pend = 1'b0;
        end
        else
            peaks = '{default: 16'h0000};
    endtask

    // Expected image from the bench copy; unused record word reads 0
    task automatic buildExp();
        event_rec_t r;
        logic [79:0] pk;
        logic [47:0] tp;
        pk = {snap[0], snap[1], snap[2], snap[3], snap[4]};
        tp = {hist[0].tempExt0, hist[0].tempExt1, hist[0].tempInt};
        expImg[0] = PREFACE_CHAR0;
        expImg[1] = PREFACE_CHAR1;
        expImg[2] = PREFACE_WORD[15:8];
        expImg[3] = PREFACE_WORD[7:0];
        expImg[4] = expCause;
        for (int b = 0; b < 10; b++)
            expImg[11+b] = pk[79-8*b -: 8];
        for (int b = 0; b < 6; b++)
            expImg[21+b] = tp[47-8*b -: 8];
        for (int j = 0; j < 6; j++)
        begin
            r = hist[j].rec;
            r.unused = 16'h0000;
            for (int b = 0; b < 20; b++)
                expImg[27+20*j+b] = r[159-8*b -: 8];
        end
    endtask

    task automatic cmpByte(input int i);
        check($sformatf("byte %0d", i), got[i], expImg[i]);
    endtask

    // Block read and full comparison; stamp counted from reset release
    task automatic readCheck(input bit extra);
        logic [47:0] st;
        log_host_model_inst.readLog(extra, ok);
        got = log_host_model_inst.img;
        check("answer", ok, 1'b1);
        check("logPresent", logPresent, present);
        check("count", log_host_model_inst.gotCount,
            present ? 147 : 0);
        if (!present)
            return;
        check("served", log_host_model_inst.nGot, 147);
        buildExp();
        for (int i = 0; i < 27; i++)
            if (i < 5 || i > 10)
                cmpByte(i);
        for (int i = 27; i < 147; i++)
            cmpByte(i);
        st = {got[10], got[9], got[8], got[7], got[6], got[5]};
        check("stamp", st, 48'(fcyc / TICK));
    endtask

    // Main sequence
    initial
    begin
        clkEn = 1'b1;
        rst = 1'b1;
        eventValid = 1'b0;
        faultValid = 1'b0;
        peakResetCmd = 1'b0;
        logClearCmd = 1'b0;
        eventData = '0;
        faultSrc = '0;
        n_errors = 0;
        check_count = 0;
        k = 8'h00;
        present = 1'b0;
        pend = 1'b0;
        expCause = 8'h00;
        fcyc = 0;
        hist = '{default: '0};
        peaks = '{default: 16'h0000};
        kinds = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'hA};
        // Both channels of every cause, then a manual store
        for (int i = 0; i < 16; i++)
        begin
            rows[i].src = '{1'b0, i[0], kinds[i/2]};
            rows[i].cause = {4'h0, kinds[i/2]} + (i[0] ? 8'h10 : 8'h00);
        end
        rows[16] = '{'{1'b1, 1'b1, 4'h3}, 8'hFF};
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        readCheck(1'b0);
        sendEvent(1'b1);
        repeat (5) sendEvent(1'b0);
        foreach (rows[r])
        begin
            pulseCmd(1'b1);
            fault(rows[r].src, rows[r].cause);
            sendEvent(1'b0);
            readCheck(1'b0);
        end
        // Frozen log: later faults and higher readings change nothing
        fault(rows[3].src, rows[3].cause);
        repeat (2) sendEvent(1'b1);
        readCheck(1'b1);
        // Erase and peak clear, then a log whose own record sets the peaks
        pulseCmd(1'b1);
        pulseCmd(1'b0);
        sendEvent(1'b0);
        fault(rows[5].src, rows[5].cause);
        sendEvent(1'b1);
        readCheck(1'b0);
        // Enable low freezes all state, so this erase is lost
        @(posedge core_clk);
        clkEn <= 1'b0;
        pulseCmd(1'b1);
        present = 1'b1;
        @(posedge core_clk);
        clkEn <= 1'b1;
        readCheck(1'b0);
        // Reset in mid-run empties log, peaks and history
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        present = 1'b0;
        pend = 1'b0;
        hist = '{default: '0};
        peaks = '{default: 16'h0000};
        readCheck(1'b0);
        sendEvent(1'b1);
        fault(rows[16].src, rows[16].cause);
        sendEvent(1'b0);
        readCheck(1'b0);
        test_done();
    end

    // Hang guard, far beyond the expected run length
    initial
    begin
        #(30000 * 25);
        n_errors++;
        test_done();
    end
endmodule // tb_top
